// ### rtl/atm_pkg.sv
// Package for the alert threshold monitor: offsets, fields, reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package atm_pkg;
    // Register address field values carried in bits [15:12]
    localparam logic [3:0] ATM_ADDR_CFG2 = 4'h2;
    localparam logic [3:0] ATM_ADDR_ALERT = 4'h3;
    localparam logic [3:0] ATM_ADDR_LOW = 4'h4;
    localparam logic [3:0] ATM_ADDR_HIGH = 4'h5;
    // Wishbone byte offsets (index times four)
    localparam logic [7:0] ATM_OFF_CFG2 = 8'h08;
    localparam logic [7:0] ATM_OFF_ALERT = 8'h0C;
    localparam logic [7:0] ATM_OFF_LOW = 8'h10;
    localparam logic [7:0] ATM_OFF_HIGH = 8'h14;
    localparam logic [7:0] ATM_OFF_RESULT_A = 8'h20;
    localparam logic [7:0] ATM_OFF_RESULT_B = 8'h24;
    localparam logic [7:0] ATM_OFF_RESULT_C = 8'h28;
    localparam logic [7:0] ATM_OFF_RESULT_D = 8'h2C;
    localparam logic [7:0] ATM_OFF_CONVERT = 8'h30;
    // Field positions
    localparam int ATM_ADDR_LSB = 12;
    localparam int ATM_THR_W = 12;
    localparam int ATM_RES_W = 16;
    localparam int ATM_NCH = 4;
    // Reset values and codes
    localparam logic [11:0] ATM_LOW_RST = 12'h800;
    localparam logic [11:0] ATM_HIGH_RST = 12'h7FF;
    localparam logic [3:0] ATM_LOW_PAD = 4'h0;
    localparam logic [3:0] ATM_HIGH_PAD = 4'hF;
    localparam logic [7:0] ATM_SOFT_RST = 8'h3C;
    localparam logic [7:0] ATM_HARD_RST = 8'hFF;
    localparam logic [7:0] ATM_CFG2_RST = 8'h00;
    localparam logic [15:0] ATM_RESULT_RST = 16'h0000;
    localparam logic [31:0] ATM_UNMAPPED_RD = 32'h0000_0000;
    // Bus answer states
    typedef enum logic {ATM_IDLE, ATM_ACK} atm_bus_t;
endpackage

// ### rtl/atm_cmp_if.sv
// Interface from the register side to the comparator.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface atm_cmp_if;
    logic [15:0] lowLimit;
    logic [15:0] highLimit;
    logic [63:0] results;
    logic [7:0] hits;
    modport regs (output lowLimit, highLimit, results, input hits);
    modport cmp (input lowLimit, highLimit, results, output hits);
endinterface

// ### rtl/atm_compare.sv
// Four-channel window comparator, purely combinational.
// Assumes results and limits share the 16-bit left-aligned format.
`timescale 1ns/1ps
module atm_compare
    import atm_pkg::*;
#(
    parameter int NCH = ATM_NCH
) (
    // Limits, results and hits
    atm_cmp_if.cmp cif
);
    // One low and one high comparison per channel, equality is no alert
    for (genvar ch = 0; ch < NCH; ch++) begin : gCh
        logic [15:0] res;
        assign res = cif.results[ch*16 +: 16];
        assign cif.hits[2*ch] = res < cif.lowLimit; // [RULE5] [RULE15]
        assign cif.hits[2*ch+1] = res > cif.highLimit; // [RULE6] [RULE15]
    end
endmodule

// ### rtl/atm_monitor.sv
// Alert threshold monitor: thresholds, sticky alert flags, Wishbone slave.
// Assumes a classic Wishbone master on core_clk; results come over the bus.
//
// How it works
// [RULE1] Low flags at bits 0,2,4,6
// [RULE2] High flags A,B,C at bits 1,3,5
// [RULE3] High flag D at bit 7
// [RULE4] Flags sticky until alert register read
// [RULE5] Low alert when result below low limit
// [RULE6] High alert when result above high limit
// [RULE7] Low limit is field, then 0x0
// [RULE8] High limit is field, then 0xF
// [RULE9] Low field resets to 0x800, read/write
// [RULE10] High field resets to 0x7FF, read/write
// [RULE11] Bits 15:12 carry the register address
// [RULE12] Flags read-only, reset to zero
// [RULE13] Soft reset code clears flags only
// [RULE14] Hard reset code restores all defaults
// [RULE15] Same format; equality sets no flag
// [RULE16] All channels together; set beats read-clear
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module atm_monitor
    import atm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Alert flags for outside use
    output logic [7:0] alertFlags
);
    atm_cmp_if cif ();
    atm_compare #(.NCH(ATM_NCH)) uCmp (.cif(cif));

    atm_bus_t busState_r;
    logic [11:0] lowField_r;
    logic [11:0] highField_r;
    logic [7:0] flags_r;
    logic [7:0] cfg2Reset_r;
    logic [15:0] result_r [ATM_NCH];
    logic convPending_r;
    logic [31:0] rdData_nxt;
    logic access;
    logic wrTake;
    logic rdTake;
    logic lowWrite;
    logic highWrite;
    logic cfgWrite;
    logic softReset;
    logic hardReset;
    logic alertRead;
    logic [7:0] lane0;
    logic [7:0] lane1;

    // One request per ack; second cycle of a request is the answer
    assign access = wb_cyc_i && wb_stb_i && (busState_r == ATM_IDLE);
    assign wrTake = access && wb_we_i;
    assign rdTake = access && !wb_we_i;
    assign lane0 = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
    assign lane1 = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
    assign cfgWrite = wrTake && (wb_adr_i == ATM_OFF_CFG2) && wb_sel_i[0];
    assign softReset = cfgWrite && (wb_dat_i[7:0] == ATM_SOFT_RST);
    assign hardReset = cfgWrite && (wb_dat_i[7:0] == ATM_HARD_RST);
    assign lowWrite = wrTake && (wb_adr_i == ATM_OFF_LOW);
    assign highWrite = wrTake && (wb_adr_i == ATM_OFF_HIGH);
    assign alertRead = rdTake && (wb_adr_i == ATM_OFF_ALERT);

    // Bus handshake: ack one cycle after the request, then drop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_r <= ATM_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (busState_r)
                ATM_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        busState_r <= ATM_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                ATM_ACK: begin
                    busState_r <= ATM_IDLE;
                    wb_ack_o <= 1'b0;
                end
                default: begin
                    busState_r <= ATM_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // Read data mux; the four control registers carry the address field in the upper nibble
    always_comb begin
        rdData_nxt = ATM_UNMAPPED_RD;
        if (wb_adr_i == ATM_OFF_CFG2) begin
            rdData_nxt = {16'h0000, ATM_ADDR_CFG2, 4'h0, cfg2Reset_r}; // [RULE11]
        end else if (wb_adr_i == ATM_OFF_ALERT) begin
            rdData_nxt = {16'h0000, ATM_ADDR_ALERT, 4'h0, flags_r}; // [RULE11]
        end else if (wb_adr_i == ATM_OFF_LOW) begin
            rdData_nxt = {16'h0000, ATM_ADDR_LOW, lowField_r}; // [RULE11] [RULE9]
        end else if (wb_adr_i == ATM_OFF_HIGH) begin
            rdData_nxt = {16'h0000, ATM_ADDR_HIGH, highField_r}; // [RULE11] [RULE10]
        end else if (wb_adr_i == ATM_OFF_RESULT_A) begin
            rdData_nxt = {16'h0000, result_r[0]};
        end else if (wb_adr_i == ATM_OFF_RESULT_B) begin
            rdData_nxt = {16'h0000, result_r[1]};
        end else if (wb_adr_i == ATM_OFF_RESULT_C) begin
            rdData_nxt = {16'h0000, result_r[2]};
        end else if (wb_adr_i == ATM_OFF_RESULT_D) begin
            rdData_nxt = {16'h0000, result_r[3]};
        end else if (wb_adr_i == ATM_OFF_CONVERT) begin
            rdData_nxt = {31'h0000_0000, convPending_r};
        end
    end

    // Read data register, loaded when a read is taken
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rdTake) begin
            wb_dat_o <= rdData_nxt;
        end
    end

    // Low threshold field, per byte lane
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowField_r <= ATM_LOW_RST; // [RULE9]
        end else if (hardReset) begin
            lowField_r <= ATM_LOW_RST; // [RULE14]
        end else if (lowWrite) begin
            if (wb_sel_i[0]) begin
                lowField_r[7:0] <= lane0;
            end
            if (wb_sel_i[1]) begin
                lowField_r[11:8] <= lane1[3:0];
            end
        end
    end

    // High threshold field, per byte lane
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            highField_r <= ATM_HIGH_RST; // [RULE10]
        end else if (hardReset) begin
            highField_r <= ATM_HIGH_RST; // [RULE14]
        end else if (highWrite) begin
            if (wb_sel_i[0]) begin
                highField_r[7:0] <= lane0;
            end
            if (wb_sel_i[1]) begin
                highField_r[11:8] <= lane1[3:0];
            end
        end
    end

    // Reset field of the second configuration register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg2Reset_r <= ATM_CFG2_RST;
        end else if (hardReset) begin
            cfg2Reset_r <= ATM_CFG2_RST; // [RULE14]
        end else if (cfgWrite) begin
            cfg2Reset_r <= wb_dat_i[7:0];
        end
    end

    // Conversion results, written by software, one per channel
    for (genvar ch = 0; ch < ATM_NCH; ch++) begin : gRes
        logic [7:0] chOff;
        assign chOff = ATM_OFF_RESULT_A + 8'(4 * ch);
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                result_r[ch] <= ATM_RESULT_RST;
            end else if (hardReset) begin
                result_r[ch] <= ATM_RESULT_RST;
            end else if (wrTake && (wb_adr_i == chOff)) begin
                if (wb_sel_i[0]) begin
                    result_r[ch][7:0] <= lane0;
                end
                if (wb_sel_i[1]) begin
                    result_r[ch][15:8] <= lane1;
                end
            end
        end
        assign cif.results[ch*16 +: 16] = result_r[ch];
    end

    // Conversion strobe: any write to the convert offset starts one compare
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            convPending_r <= 1'b0;
        end else begin
            convPending_r <= wrTake && (wb_adr_i == ATM_OFF_CONVERT) && !hardReset;
        end
    end

    // Internal 16-bit limits, left-aligned with fixed low nibbles
    assign cif.lowLimit = {lowField_r, ATM_LOW_PAD}; // [RULE7]
    assign cif.highLimit = {highField_r, ATM_HIGH_PAD}; // [RULE8]

    // Sticky flags: new hits win over a read clear or a soft reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_r <= 8'h00; // [RULE12]
        end else if (hardReset) begin
            flags_r <= 8'h00; // [RULE14]
        end else if (alertRead || softReset) begin
            flags_r <= convPending_r ? cif.hits : 8'h00; // [RULE4] [RULE13] [RULE16]
        end else if (convPending_r) begin
            flags_r <= flags_r | cif.hits; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE16]
        end
    end

    // Flags mirrored out from a register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alertFlags <= 8'h00;
        end else begin
            alertFlags <= flags_r; // [RULE12]
        end
    end
endmodule

// ### dv/atm_monitor_props.sv
// Checker for the monitor: bus answer, address nibble, flag moves.
// Assumes one clock and a classic Wishbone master.
`timescale 1ns/1ps
module atm_monitor_props
    import atm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Bus and flags
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] alertFlags
);
    logic req;
    logic rdAck;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] prevFlags_r;
    logic [2:0] convAge_r;
    logic [2:0] clrAge_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Decode of requests and flag edges
    assign req = wb_cyc_i && wb_stb_i;
    assign rdAck = wb_ack_o && !wb_we_i;
    assign rise = alertFlags & ~prevFlags_r;
    assign fall = prevFlags_r & ~alertFlags;
    // Saturating ages since a conversion and since a clearing access
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prevFlags_r <= 8'h00;
            convAge_r <= 3'h7;
            clrAge_r <= 3'h7;
        end else begin
            prevFlags_r <= alertFlags;
            convAge_r <= (req && wb_we_i && wb_adr_i == ATM_OFF_CONVERT) ? 3'h0
                : convAge_r + 3'(convAge_r != 3'h7);
            clrAge_r <= (req && (wb_we_i ? wb_adr_i == ATM_OFF_CFG2
                : wb_adr_i == ATM_OFF_ALERT)) ? 3'h0 : clrAge_r + 3'(clrAge_r != 3'h7);
        end
    end
    property p_ack_next; req && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than a cycle");
    property p_ack_cause; wb_ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_nib_low; rdAck && wb_adr_i == ATM_OFF_LOW |-> wb_dat_o[15:12] == 4'h4; endproperty
    a_nib_low: assert property (p_nib_low) else $error("low limit nibble");
    property p_nib_alert; rdAck && wb_adr_i == ATM_OFF_ALERT |-> wb_dat_o[15:12] == 4'h3; endproperty
    a_nib_alert: assert property (p_nib_alert) else $error("flag nibble");
    property p_rst_zero; $rose(arst_n) |-> alertFlags == 8'h00; endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("flags after reset");
    property p_keep; |fall |-> clrAge_r <= 3'h4; endproperty
    a_keep: assert property (p_keep) else $error("flag dropped unread");
    property p_set; |rise |-> convAge_r <= 3'h5; endproperty
    a_set: assert property (p_set) else $error("flag set without conversion");
    c_set: cover property (|rise);
    c_clr: cover property (|fall);
    c_rd: cover property (rdAck && wb_adr_i == ATM_OFF_ALERT);
endmodule
bind atm_monitor atm_monitor_props u_props (
    .core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alertFlags(alertFlags)
);

// ### dv/atm_wb_host.sv
// Host model: classic Wishbone master owning the monitor's bus inputs.
// Assumes xfer is entered right after a rising clock edge.
`timescale 1ns/1ps
module atm_wb_host (
    // Clock and answer
    input wire logic core_clk,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Request
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [7:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i
);
    // Idle bus from time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
    end
    // One cycle held until ack is sampled, then a gap cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            output logic [31:0] rdat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= dat;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule

// ### dv/tb_top.sv
// Bench for the alert threshold monitor: limits, flags, resets.
// Assumes the host model drives the bus on a 20 MHz clock.
`timescale 1ns/1ps
module tb_top
    import atm_pkg::*;
;
    localparam logic [63:0] P_LOHI = 64'h0FFF_2010_0FFF_2010;
    localparam logic [63:0] P_HILO = 64'h2010_0FFF_2010_0FFF;
    localparam logic [63:0] P_EQ = 64'h1000_200F_1000_200F;
    logic core_clk, arst_n, cyc, stb, we, ack;
    logic [7:0] adr, flags;
    logic [3:0] sel;
    logic [31:0] datW, datR;
    int fails = 0;
    int numChecks = 0;
    int cycles = 0;
    atm_wb_host host (.core_clk(core_clk), .wb_ack_o(ack), .wb_dat_o(datR), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW));
    atm_monitor dut (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
        .wb_ack_o(ack), .alertFlags(flags));
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (fails == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, {16'h0000, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0000_0000, r);
        check(r[15:0], exp);
    endtask
    // Load four results and start one conversion
    task automatic conv(input logic [63:0] res);
        wr(ATM_OFF_RESULT_A, res[63:48]);
        wr(ATM_OFF_RESULT_B, res[47:32]);
        wr(ATM_OFF_RESULT_C, res[31:16]);
        wr(ATM_OFF_RESULT_D, res[15:0]);
        wr(ATM_OFF_CONVERT, 16'h0001);
        repeat (3) @(posedge core_clk);
    endtask
    // Defaults and an unmapped read
    task automatic t_defaults;
        rd(ATM_OFF_LOW, 16'h4800);
        rd(ATM_OFF_HIGH, 16'h57FF);
        rd(ATM_OFF_ALERT, 16'h3000);
        check({8'h00, flags}, 16'h0000);
        rd(8'h40, 16'h0000);
    endtask
    // Limits one step off each result; equality, sides, stickiness
    task automatic t_limits;
        wr(ATM_OFF_LOW, 16'h4100);
        wr(ATM_OFF_HIGH, 16'h5200);
        rd(ATM_OFF_LOW, 16'h4100);
        rd(ATM_OFF_HIGH, 16'h5200);
        conv(P_EQ);
        rd(ATM_OFF_ALERT, 16'h3000);
        conv(P_HILO);
        check({8'h00, flags}, 16'h0066);
        wr(ATM_OFF_ALERT, 16'h3000);
        rd(ATM_OFF_ALERT, 16'h3066);
        check({8'h00, flags}, 16'h0000);
        conv(P_LOHI);
        conv(P_EQ);
        check({8'h00, flags}, 16'h0099);
        rd(ATM_OFF_ALERT, 16'h3099);
        rd(ATM_OFF_ALERT, 16'h3000);
    endtask
    // Soft reset keeps the low limit; hard reset restores both limits
    task automatic t_resets;
        conv(P_LOHI);
        wr(ATM_OFF_CFG2, 16'h203C);
        rd(ATM_OFF_ALERT, 16'h3000);
        rd(ATM_OFF_LOW, 16'h4100);
        wr(ATM_OFF_CFG2, 16'h20FF);
        rd(ATM_OFF_LOW, 16'h4800);
        rd(ATM_OFF_HIGH, 16'h57FF);
    endtask
    // Main sequence
    initial begin
        arst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_defaults();
        t_limits();
        t_resets();
        print_verdict();
    end
endmodule
